// *** core/sbc_chan_combiner.sv ***
// wired-or of the output commands toward units with good communication onto the outgoing channel map
`timescale 1ns/1ps
module sbc_chan_combiner
   import sbc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // carrier
   sbc_tx_if.combiner tx
);
   sbc_chmap_t next_on;
   sbc_chmap_t next_test;
   sbc_chmap_t on_q;
   sbc_chmap_t test_q;

   // ***********************************************
   // combine destinations
   // ***********************************************
   always_comb
   begin
      next_on   = '0;
      next_test = '0;
      for (int i = 0; i < NPT; i++)
      begin
         // a destination set to none adds nothing
         if (tx.so_cmd[i] && sel_ok(tx.so_cfg[i].fu1, tx.so_cfg[i].ch1)
             && tx.comm_ok[fu_index(1'(i / NPC), tx.so_cfg[i].fu1)])
         begin
            next_on[fu_index(1'(i / NPC), tx.so_cfg[i].fu1)][tx.so_cfg[i].ch1 - 4'h1] = 1'b1;
         end
         if (tx.so_cmd[i] && sel_ok(tx.so_cfg[i].fu2, tx.so_cfg[i].ch2)
             && tx.comm_ok[fu_index(1'(i / NPC), tx.so_cfg[i].fu2)])
         begin
            next_on[fu_index(1'(i / NPC), tx.so_cfg[i].fu2)][tx.so_cfg[i].ch2 - 4'h1] = 1'b1;
         end
      end
      if (tx.test_flag)
      begin
         next_test = next_on;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         on_q   <= '0;
         test_q <= '0;
      end
      else
      begin
         on_q   <= next_on;
         test_q <= next_test;
      end
   end

   assign tx.tx_on   = on_q;
   assign tx.tx_test = test_q;

   // ***********************************************
   // checks
   // ***********************************************
   logic [NFU-1:0] fu_busy;
   always_comb
   begin
      for (int f = 0; f < NFU; f++)
      begin
         fu_busy[f] = |on_q[f];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_comm_gates_drive: assert property ((fu_busy & ~$past(tx.comm_ok)) == '0)
      else $error("channel driven toward a unit with bad communication");
   a_test_only_driven: assert property ((test_q & ~on_q) == '0 ##0 (test_q == on_q || !$past(tx.test_flag)))
      else $error("test bit does not follow driven channels");
   a_idle_no_drive: assert property ($past(tx.so_cmd) == '0 |-> on_q == '0)
      else $error("channel driven with no command on");
   c_channel_driven: cover property (fu_busy != '0 ##1 fu_busy == '0);
endmodule : sbc_chan_combiner

// *** core/sbc_pkg.sv ***
// shared channel i/o: constants, layouts and types
package sbc_pkg;
   localparam int NPT   = 32;
   localparam int NCARD = 2;
   localparam int NPC   = 16;
   localparam int NFPC  = 8;
   localparam int NFU   = 16;
   localparam int NCH   = 15;

   // apb byte offsets
   localparam logic [11:0] OFS_SI_CFG   = 12'h000;
   localparam logic [11:0] OFS_SO_CFG   = 12'h080;
   localparam logic [11:0] OFS_SI_OPER  = 12'h100;
   localparam logic [11:0] OFS_SI_RECV  = 12'h104;
   localparam logic [11:0] OFS_SI_TEST  = 12'h108;
   localparam logic [11:0] OFS_SO_CMD   = 12'h10c;
   localparam logic [11:0] OFS_EVT_STAT = 12'h110;
   localparam logic [11:0] OFS_EVT_MASK = 12'h114;
   localparam logic [11:0] CFG_SPAN     = 12'h080;

   // config field layouts
   typedef struct packed {
      logic       evt_en;
      logic [3:0] ch;
      logic [3:0] fu;
   } sbc_si_cfg_t;

   typedef struct packed {
      logic [3:0] ch2;
      logic [3:0] fu2;
      logic [3:0] ch1;
      logic [3:0] fu1;
   } sbc_so_cfg_t;

   localparam sbc_si_cfg_t SI_CFG_RST = 9'h110;
   localparam sbc_so_cfg_t SO_CFG_RST = 16'h1010;
   localparam logic [31:0] EVT_MASK_RST = 32'h0000_0000;

   typedef logic [NFU-1:0][NCH-1:0] sbc_chmap_t;

   typedef enum logic [1:0] {tm_disabled, tm_isolated, tm_forcible} sbc_tmode_t;
   typedef enum logic [1:0] {rx_off, rx_on, flagged_test_off_state, flagged_test_on_state} sbc_rx_t;
   typedef enum logic {apb_idle, apb_answer} sbc_apb_t;

   // valid origin/destination: unit 1..8 on the card, channel 1..15
   function automatic logic sel_ok(input logic [3:0] fu, input logic [3:0] ch);
      sel_ok = (fu != 4'h0) && (fu <= 4'h8) && (ch != 4'h0);
   endfunction : sel_ok

   function automatic logic [3:0] fu_index(input logic card, input logic [3:0] fu);
      fu_index = {card, 3'h0} + fu - 4'h1;
   endfunction : fu_index
endpackage : sbc_pkg

// *** core/sbc_shared_io.sv ***
// shared binary channel i/o core with apb register access
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module sbc_shared_io
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // relay state
   input  wire logic [1:0]  card_present,
   input  wire sbc_tmode_t  test_mode,
   input  wire logic        major_selftest_fail,
   input  wire logic [31:0] so_operand,
   // local operands
   output logic      [31:0] si_operand,
   output logic      [31:0] si_operand_n,
   output logic             irq,
   // field unit channels
   input  wire sbc_chmap_t  fu_rx_on,
   input  wire sbc_chmap_t  fu_rx_test,
   input  wire logic [15:0] fu_comm_ok,
   output sbc_chmap_t       fu_tx_on,
   output sbc_chmap_t       fu_tx_test
);
   sbc_tx_if tx ();

   sbc_si_cfg_t si_cfg      [NPT];
   sbc_si_cfg_t next_si_cfg [NPT];
   sbc_so_cfg_t so_cfg      [NPT];
   sbc_so_cfg_t next_so_cfg [NPT];
   logic [31:0] si_recv;
   logic [31:0] si_test;
   logic [31:0] so_cmd;
   logic [31:0] evt_stat;
   logic [31:0] evt_mask;
   logic        test_flag;
   logic [15:0] comm_ok;
   logic [31:0] next_si_operand;
   logic [31:0] next_si_recv;
   logic [31:0] next_si_test;
   logic [31:0] next_so_cmd;
   logic [31:0] next_evt_stat;
   logic [31:0] next_evt_mask;
   logic [31:0] evt_hit;
   logic        next_irq;
   logic        next_test_flag;
   sbc_apb_t    apb_st;
   sbc_apb_t    next_apb_st;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        wr_en;
   logic        addr_ok;
   logic [4:0]  widx;

   function automatic sbc_rx_t rx_state(input logic on, input logic tb);
      case ({tb, on})
         2'b00:   rx_state = rx_off;
         2'b01:   rx_state = rx_on;
         2'b10:   rx_state = flagged_test_off_state;
         2'b11:   rx_state = flagged_test_on_state;
         default: rx_state = rx_off;
      endcase
   endfunction : rx_state

   // ***********************************************
   // apb decode and answer
   // ***********************************************
   assign widx    = paddr[6:2];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_EVT_MASK);
   assign wr_en   = psel && penable && pwrite && (apb_st == apb_answer) && addr_ok;

   always_comb
   begin
      next_apb_st  = apb_idle;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      case (apb_st)
         apb_idle:
         begin
            if (psel && penable)
            begin
               next_apb_st  = apb_answer;
               next_pready  = 1'b1;
               next_pslverr = !addr_ok;
               next_prdata  = 32'h0000_0000;
               if (addr_ok && !pwrite)
               begin
                  if (paddr < OFS_SO_CFG)
                  begin
                     next_prdata = {23'h000000, si_cfg[widx]};
                  end
                  else if (paddr < OFS_SO_CFG + CFG_SPAN)
                  begin
                     next_prdata = {16'h0000, so_cfg[widx]};
                  end
                  else
                  begin
                     case (paddr)
                        OFS_SI_OPER:  next_prdata = si_operand;
                        OFS_SI_RECV:  next_prdata = si_recv;
                        OFS_SI_TEST:  next_prdata = si_test;
                        OFS_SO_CMD:   next_prdata = so_cmd;
                        OFS_EVT_STAT: next_prdata = evt_stat;
                        OFS_EVT_MASK: next_prdata = evt_mask;
                        default:      next_prdata = 32'h0000_0000;
                     endcase
                  end
               end
            end
         end
         apb_answer:
         begin
            next_apb_st = apb_idle;
         end
         default:
         begin
            next_apb_st = apb_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         apb_st  <= apb_idle;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         apb_st  <= next_apb_st;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end
   end

   // ***********************************************
   // settings
   // ***********************************************
   always_comb
   begin
      for (int i = 0; i < NPT; i++)
      begin
         next_si_cfg[i] = si_cfg[i];
         next_so_cfg[i] = so_cfg[i];
      end
      next_evt_mask = evt_mask;
      if (wr_en)
      begin
         if (paddr < OFS_SO_CFG)
         begin
            next_si_cfg[widx] = pwdata[8:0];
         end
         else if (paddr < OFS_SO_CFG + CFG_SPAN)
         begin
            next_so_cfg[widx] = pwdata[15:0];
         end
         else if (paddr == OFS_EVT_MASK)
         begin
            next_evt_mask = pwdata;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NPT; i++)
         begin
            si_cfg[i] <= SI_CFG_RST;
            so_cfg[i] <= SO_CFG_RST;
         end
         evt_mask <= EVT_MASK_RST;
      end
      else
      begin
         for (int i = 0; i < NPT; i++)
         begin
            si_cfg[i] <= next_si_cfg[i];
            so_cfg[i] <= next_so_cfg[i];
         end
         evt_mask <= next_evt_mask;
      end
   end

   // ***********************************************
   // input points, events and interrupt
   // ***********************************************
   always_comb
   begin
      next_si_recv    = '0;
      next_si_test    = '0;
      next_si_operand = '0;
      evt_hit         = '0;
      for (int i = 0; i < NPT; i++)
      begin
         // origin none, bad channel or absent card reads off
         if (card_present[i / NPC] && sel_ok(si_cfg[i].fu, si_cfg[i].ch))
         begin
            // echoed channel state already holds the or of every sender
            next_si_recv[i] = fu_rx_on[fu_index(1'(i / NPC), si_cfg[i].fu)][si_cfg[i].ch - 4'h1];
            next_si_test[i] = fu_rx_test[fu_index(1'(i / NPC), si_cfg[i].fu)][si_cfg[i].ch - 4'h1];
         end
         // only isolated or forcible lets a flagged channel through
         next_si_operand[i] = next_si_recv[i] && (!next_si_test[i] || next_test_flag);
         evt_hit[i] = si_cfg[i].evt_en
                      && rx_state(next_si_recv[i], next_si_test[i]) != rx_state(si_recv[i], si_test[i]);
      end
      // a new event wins over a clear in the same cycle
      next_evt_stat = evt_stat;
      if (wr_en && paddr == OFS_EVT_STAT)
      begin
         next_evt_stat = evt_stat & ~pwdata;
      end
      next_evt_stat = next_evt_stat | evt_hit;
      next_irq      = |(next_evt_stat & next_evt_mask);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         si_recv      <= '0;
         si_test      <= '0;
         si_operand   <= '0;
         si_operand_n <= '1;
         evt_stat     <= '0;
         irq          <= 1'b0;
      end
      else
      begin
         si_recv      <= next_si_recv;
         si_test      <= next_si_test;
         si_operand   <= next_si_operand;
         si_operand_n <= ~next_si_operand;
         evt_stat     <= next_evt_stat;
         irq          <= next_irq;
      end
   end

   // ***********************************************
   // output points
   // ***********************************************
   always_comb
   begin
      next_test_flag = (test_mode == tm_isolated) || (test_mode == tm_forcible);
      for (int i = 0; i < NPT; i++)
      begin
         next_so_cmd[i] = so_operand[i] && card_present[i / NPC] && !major_selftest_fail;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         so_cmd    <= '0;
         test_flag <= 1'b0;
         comm_ok   <= '0;
      end
      else
      begin
         so_cmd    <= next_so_cmd;
         test_flag <= next_test_flag;
         comm_ok   <= fu_comm_ok;
      end
   end

   always_comb
   begin
      tx.so_cmd    = so_cmd;
      tx.comm_ok   = comm_ok;
      tx.test_flag = test_flag;
      for (int i = 0; i < NPT; i++)
      begin
         tx.so_cfg[i] = so_cfg[i];
      end
   end

   sbc_chan_combiner u_comb (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tx       (tx.combiner)
   );

   assign fu_tx_on   = tx.tx_on;
   assign fu_tx_test = tx.tx_test;

   // ***********************************************
   // checks
   // ***********************************************
   logic [31:0] none_mask;
   always_comb
   begin
      for (int i = 0; i < NPT; i++)
      begin
         none_mask[i] = (si_cfg[i].fu == 4'h0);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_oper_needs_recv: assert property ((si_operand & ~si_recv) == '0 && si_operand_n == ~si_operand)
      else $error("operand on without received channel or complement wrong");
   a_test_gates_oper: assert property ($past(test_mode) == tm_disabled |-> (si_operand & si_test) == '0)
      else $error("test flagged channel reached operand in normal mode");
   a_none_reads_off: assert property ((($past(none_mask)) & (si_recv | si_test | si_operand)) == '0)
      else $error("input point with no origin reads on");
   a_selftest_blocks: assert property ($past(major_selftest_fail) |-> so_cmd == '0)
      else $error("output command on during self-test failure");
   a_cmd_follows_op: assert property (!$past(major_selftest_fail) && $past(card_present) == 2'h3
                                      |-> so_cmd == $past(so_operand))
      else $error("output command does not follow its operand");
   a_evt_sticky: assert property (evt_stat[0] && !(wr_en && paddr == OFS_EVT_STAT) |=> evt_stat[0])
      else $error("event status bit lost without a clear");
   a_evt_on_change: assert property ($past(si_cfg[0].evt_en) && $changed({si_recv[0], si_test[0]})
                                     |-> evt_stat[0])
      else $error("channel change with events on was not logged");
   a_irq_level: assert property (irq == |(evt_stat & evt_mask))
      else $error("interrupt does not match masked status");
   a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle after access");
   a_tx_latency: assert property (so_cmd == '0 [*2] |=> fu_tx_on == '0)
      else $error("channel driven with commands off");

   c_evt_logged: cover property (evt_stat != '0 ##1 irq);
   c_test_oper: cover property ((si_operand & si_test) != '0);
   c_apb_write: cover property (wr_en ##1 !pready);
   c_two_dest: cover property (so_cmd[0] && so_cfg[0].fu1 != 4'h0 && so_cfg[0].fu2 != 4'h0);
endmodule : sbc_shared_io

// *** core/sbc_tx_if.sv ***
// carrier between the core and the channel combiner
`timescale 1ns/1ps
interface sbc_tx_if;
   import sbc_pkg::*;
   logic [NPT-1:0] so_cmd;
   sbc_so_cfg_t    so_cfg [NPT];
   logic [NFU-1:0] comm_ok;
   logic           test_flag;
   sbc_chmap_t     tx_on;
   sbc_chmap_t     tx_test;
   modport core     (output so_cmd, so_cfg, comm_ok, test_flag, input tx_on, tx_test);
   modport combiner (input so_cmd, so_cfg, comm_ok, test_flag, output tx_on, tx_test);
endinterface : sbc_tx_if

// *** testbench/sbc_fu_echo.sv ***
// field unit model: echoes the or of every relay's channels back to all relays
`timescale 1ns/1ps
module sbc_fu_echo
   import sbc_pkg::*;
(
   // clock
   input  wire logic       core_clk,
   // senders: this relay and the other relays on the unit
   input  wire sbc_chmap_t dut_on,
   input  wire sbc_chmap_t dut_test,
   input  wire sbc_chmap_t peer_on,
   input  wire sbc_chmap_t peer_test,
   // echo seen by every relay
   output sbc_chmap_t      echo_on,
   output sbc_chmap_t      echo_test
);
   // one link hop of delay; a channel is on while any sender holds it on
   always_ff @(posedge core_clk)
   begin
      echo_on   <= dut_on | peer_on;
      echo_test <= dut_test | peer_test;
   end
endmodule : sbc_fu_echo

// *** testbench/sbc_shared_io_bench.sv ***
// self-checking bench for the shared channel i/o core
`timescale 1ns/1ps
module sbc_shared_io_bench;
   import sbc_pkg::*;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, fail, rd_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, so_operand, si_operand, si_operand_n, rd_data;
   logic [1:0]  card_present;
   logic [15:0] comm_ok;
   sbc_tmode_t  test_mode;
   sbc_chmap_t  rx_on, rx_test, tx_on, tx_test, peer_on, peer_test;
   int          bad_count, samples_checked;

   sbc_shared_io dut_u (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .card_present(card_present), .test_mode(test_mode), .major_selftest_fail(fail),
      .so_operand(so_operand), .si_operand(si_operand), .si_operand_n(si_operand_n), .irq(irq),
      .fu_rx_on(rx_on), .fu_rx_test(rx_test), .fu_comm_ok(comm_ok), .fu_tx_on(tx_on), .fu_tx_test(tx_test));
   sbc_fu_echo echo_u (.core_clk(core_clk), .dut_on(tx_on), .dut_test(tx_test), .peer_on(peer_on),
      .peer_test(peer_test), .echo_on(rx_on), .echo_test(rx_test));

   // ************************************
   // tasks
   // ************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdat);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdat;
      @(posedge core_clk);
      penable <= 1'h1;
      // no cycle count assumed: pready ends this wait, or the watchdog if it never comes
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'h1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic rd(input logic [11:0] addr);
      apb(1'h0, addr, 32'h0);
   endtask : rd

   task automatic wr(input logic [11:0] addr, input logic [31:0] d);
      apb(1'h1, addr, d);
   endtask : wr

   // output to echo to operand takes four edges
   task automatic settle;
      repeat (6) @(posedge core_clk);
   endtask : settle

   // ************************************
   // clock, watchdog and tests
   // ************************************
   initial
   begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end

   // tests take well under 1000 cycles
   initial
   begin
      #20000;
      bad_count++;
      final_report();
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, fail, rd_err} = 6'h0;
      {paddr, pwdata, so_operand, rd_data} = '0;
      {peer_on, peer_test} = '0;
      card_present = 2'h3;
      comm_ok = 16'hffff;
      test_mode = tm_disabled;
      bad_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'h1;
      rd(OFS_SI_CFG);
      chk(rd_data, 32'h0000_0110);
      rd(OFS_SO_CFG + 12'h004);
      chk(rd_data, 32'h0000_1010);
      rd(12'h118);
      chk({31'h0, rd_err}, 32'h1);
      $display("test defaults done");
      wr(OFS_SO_CFG, 32'h0000_5231);
      wr(OFS_SI_CFG, 32'h0000_0131);
      wr(OFS_SI_CFG + 12'h008, 32'h0000_0152);
      @(posedge core_clk);
      peer_on[0][0] <= 1'h1;
      so_operand <= 32'h3;
      settle();
      chk({17'h0, tx_on[0]}, 32'h4);
      chk({17'h0, tx_on[1]}, 32'h10);
      chk({17'h0, tx_on[15]}, 32'h0);
      chk(si_operand, 32'h5);
      rd(OFS_SO_CMD);
      chk(rd_data, 32'h3);
      rd(OFS_SI_RECV);
      chk(rd_data, 32'h5);
      $display("test mapping done");
      @(posedge core_clk);
      peer_on[0][2] <= 1'h1;
      so_operand <= 32'h0;
      settle();
      chk(si_operand, 32'h1);
      @(posedge core_clk);
      peer_on[0][2] <= 1'h0;
      settle();
      chk(si_operand, 32'h0);
      chk({31'h0, si_operand_n[0]}, 32'h1);
      $display("test wired or done");
      @(posedge core_clk);
      peer_on[0][2] <= 1'h1;
      peer_test[0][2] <= 1'h1;
      settle();
      chk(si_operand, 32'h0);
      rd(OFS_SI_RECV);
      chk(rd_data, 32'h1);
      rd(OFS_SI_TEST);
      chk(rd_data, 32'h1);
      for (int m = 1; m <= 2; m++)
      begin
         @(posedge core_clk);
         test_mode <= sbc_tmode_t'(m);
         settle();
         chk(si_operand, 32'h1);
      end
      @(posedge core_clk);
      peer_on[0][2] <= 1'h0;
      peer_test[0][2] <= 1'h0;
      test_mode <= tm_isolated;
      so_operand <= 32'h1;
      settle();
      chk({17'h0, tx_test[0]}, 32'h4);
      @(posedge core_clk);
      test_mode <= tm_disabled;
      fail <= 1'h1;
      settle();
      chk({17'h0, tx_test[0]}, 32'h0);
      chk({17'h0, tx_on[0]}, 32'h0);
      rd(OFS_SO_CMD);
      chk(rd_data, 32'h0);
      @(posedge core_clk);
      fail <= 1'h0;
      comm_ok <= 16'hfffd;
      settle();
      chk({17'h0, tx_on[1]}, 32'h0);
      chk({17'h0, tx_on[0]}, 32'h4);
      $display("test test bit and supervision done");
      @(posedge core_clk);
      comm_ok <= 16'hffff;
      so_operand <= 32'h0;
      settle();
      wr(OFS_EVT_STAT, 32'hffff_ffff);
      wr(OFS_EVT_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0);
      @(posedge core_clk);
      peer_on[0][2] <= 1'h1;
      settle();
      chk({31'h0, irq}, 32'h1);
      rd(OFS_EVT_STAT);
      chk(rd_data, 32'h1);
      wr(OFS_EVT_STAT, 32'h1);
      settle();
      chk({31'h0, irq}, 32'h0);
      @(posedge core_clk);
      peer_test[0][2] <= 1'h1;
      settle();
      chk({31'h0, irq}, 32'h1);
      wr(OFS_EVT_STAT, 32'h1);
      wr(OFS_SI_CFG, 32'h0000_0031);
      @(posedge core_clk);
      peer_on[0][2] <= 1'h0;
      peer_test[0][2] <= 1'h0;
      settle();
      rd(OFS_EVT_STAT);
      chk(rd_data, 32'h0);
      $display("test events done");
      wr(OFS_SI_CFG + 12'h040, 32'h0000_0111);
      @(posedge core_clk);
      peer_on[8][0] <= 1'h1;
      settle();
      chk(si_operand, 32'h0001_0000);
      @(posedge core_clk);
      card_present <= 2'h1;
      settle();
      chk(si_operand, 32'h0);
      $display("test second card done");
      final_report();
   end
endmodule : sbc_shared_io_bench
